// ===== design/tmp_defines.svh
// register offsets, field positions, reset values and timing counts for the timer block
// assumes inclusion by bare name from the design module
`ifndef TMP_DEFINES_SVH
`define TMP_DEFINES_SVH

// byte addresses on the bus (word aligned), and the word index of the count register
`define TMP_ADDR_COUNT 8'h04
`define TMP_ADDR_CONFIG 8'h08
`define TMP_ADDR_CMD 8'h0C
`define TMP_COUNT_INDEX 8'h01

// config field positions
`define TMP_CFG_SRC_BIT 5
`define TMP_CFG_EDGE_BIT 4
`define TMP_CFG_ASSIGN_BIT 3
`define TMP_CFG_RATIO_HI 2
`define TMP_CFG_RATIO_LO 0
`define TMP_CFG_RESET 8'h3F

// command register bits
`define TMP_CMD_WDT_CLEAR_BIT 0

// timing
`define TMP_PHASES_PER_CYCLE 3'h4
`define TMP_WRITE_HOLD_CYCLES 2'h2

`endif

// ===== design/tmp_pkg.sv
// types shared by the timer block
// assumes the defines header sits beside it
package tmp_pkg;
  typedef logic [7:0] tmp_byte_t;
  typedef logic [1:0] tmp_phase_t;
endpackage : tmp_pkg

// ===== design/tmp_timer.sv
// eight-bit timer/counter with shared prescaler, classic wishbone slave
// assumes one 250 MHz clock standing for the oscillator; four clocks form one instruction cycle
`timescale 1ns/100ps

`include "tmp_defines.svh"

module tmp_timer
  import tmp_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // pin and watchdog links
  input wire logic external_count_input_i,
  input wire logic watchdog_clear_instr_i,
  output logic watchdog_tick_o,
  output logic [7:0] timer_count_o
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // selects the prescaler bit whose toggle divides by 2^(n+1)
  function automatic logic ratio_tap(input logic [PRESCALE_WIDTH-1:0] cnt,
                                     input logic [2:0] n);
    ratio_tap = cnt[n];
  endfunction : ratio_tap

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic req;
  logic hit_count;
  logic hit_config;
  logic hit_cmd;
  logic wr_count;
  logic wr_config;
  logic wr_cmd;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign hit_count = (wb_adr_i == `TMP_ADDR_COUNT);
  assign hit_config = (wb_adr_i == `TMP_ADDR_CONFIG);
  assign hit_cmd = (wb_adr_i == `TMP_ADDR_CMD);
  // writes take effect on the single cycle the ack is raised
  assign wr_count = req && wb_we_i && hit_count && wb_sel_i[0];
  assign wr_config = req && wb_we_i && hit_config && wb_sel_i[0];
  assign wr_cmd = req && wb_we_i && hit_cmd && wb_sel_i[0];

  // one-cycle answer; unmapped addresses get err instead of ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= req && (hit_count || hit_config || hit_cmd);
      wb_err_o <= req && !(hit_count || hit_config || hit_cmd);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration register (write-only on the device; readable here for debug is avoided)

  tmp_byte_t cfg_q;
  logic src_sel;
  logic edge_sel;
  logic assign_wdt;
  logic [2:0] ratio;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= `TMP_CFG_RESET;
    end else if (wr_config) begin
      cfg_q <= {2'b00, wb_dat_i[5:0]};
    end
  end

  assign src_sel = cfg_q[`TMP_CFG_SRC_BIT];
  assign edge_sel = cfg_q[`TMP_CFG_EDGE_BIT];
  assign assign_wdt = cfg_q[`TMP_CFG_ASSIGN_BIT];
  assign ratio = cfg_q[`TMP_CFG_RATIO_HI:`TMP_CFG_RATIO_LO];

  //////////////////////////////////////////////////////////////////////////////
  // instruction-cycle phase counter: phases 0..3 stand for Q1..Q4

  tmp_phase_t phase_q;
  logic cycle_end;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign cycle_end = (phase_q == 2'h3);

  //////////////////////////////////////////////////////////////////////////////
  // external input: two-flop synchroniser, then edge select

  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic src_level;
  logic src_rise;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= external_count_input_i;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // inverting the level makes a falling pin edge look like a rising one
  assign src_level = pin_sync_q ^ edge_sel;
  assign src_rise = src_level && !(pin_prev_q ^ edge_sel);

  //////////////////////////////////////////////////////////////////////////////
  // shared prescaler; replaces the ripple chain with a synchronous counter whose
  // selected bit toggles, so its output stays symmetric

  logic [PRESCALE_WIDTH-1:0] presc_q;
  logic presc_step;
  logic presc_clear;
  logic cmd_wdt_clear;

  assign cmd_wdt_clear = watchdog_clear_instr_i
                         || (wr_cmd && wb_dat_i[`TMP_CMD_WDT_CLEAR_BIT]);
  // timer mode, or any mode with the prescaler on the watchdog, feeds instruction cycles; counter mode on the timer feeds selected input edges
  assign presc_step = assign_wdt ? cycle_end : (src_sel ? src_rise : cycle_end);
  assign presc_clear = (wr_count && !assign_wdt)
                       || (cmd_wdt_clear && assign_wdt);

  // no bus path reads or loads this counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_q <= '0;
    end else if (presc_clear) begin
      presc_q <= '0;
    end else if (presc_step) begin
      presc_q <= presc_q + 1'b1;
    end
  end

  // postscaled watchdog tick, only while assigned to the watchdog
  logic wdt_prev_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_prev_q <= 1'b0;
      watchdog_tick_o <= 1'b0;
    end else begin
      wdt_prev_q <= ratio_tap(presc_q, ratio);
      watchdog_tick_o <= assign_wdt && wdt_prev_q && !ratio_tap(presc_q, ratio);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // prescaler output and phase-two/phase-four sampling

  logic presc_out;
  logic samp_q2_q;
  logic samp_q4_q;
  logic tick;

  // divide 2^(ratio+1): the inverted tap rises when the tapped bit carries out,
  // so after a clear the first count comes a full ratio later, not half of it
  always_comb begin
    if (assign_wdt) begin
      presc_out = src_sel ? src_level : phase_q[1];
    end else begin
      presc_out = ~ratio_tap(presc_q, ratio);
    end
  end

  // sample at phase two (index 1) and phase four (index 3); reset loads the
  // idle level so that no false edge is counted right after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samp_q2_q <= presc_out;
      samp_q4_q <= presc_out;
    end else begin
      if (phase_q == 2'h1) begin
        samp_q2_q <= presc_out;
      end
      if (phase_q == 2'h3) begin
        samp_q4_q <= samp_q2_q;
      end
    end
  end

  // a rising edge seen across the two samples advances the count at cycle end;
  // pin latency then falls inside four to eight oscillator periods
  assign tick = cycle_end && samp_q2_q && !samp_q4_q;

  // timer mode with no prescaler counts every cycle directly
  logic inc;
  assign inc = (!src_sel && assign_wdt) ? cycle_end : tick;

  //////////////////////////////////////////////////////////////////////////////
  // write hold-off: two whole instruction cycles without counting

  logic [1:0] hold_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= 2'h0;
    end else if (wr_count) begin
      hold_q <= `TMP_WRITE_HOLD_CYCLES;
    end else if (cycle_end && hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // count register

  tmp_byte_t count_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= 8'h00;
    end else if (wr_count) begin
      count_q <= wb_dat_i[7:0];
    end else if (inc && hold_q == 2'h0) begin
      count_q <= count_q + 8'h01;
    end
  end

  assign timer_count_o = count_q;

  //////////////////////////////////////////////////////////////////////////////
  // read data: config and command read as zero, as the config is write-only

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i && hit_count) begin
      wb_dat_o <= {24'h00_0000, count_q};
    end else if (req) begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // kept by the pin source and by software

endmodule : tmp_timer

// ===== tb/tmp_pulse_src.sv
// count pin source: flips the pin once per enabled clock
// assumes the bench spaces its enables far apart
`timescale 1ns/100ps
module tmp_pulse_src (
  input wire logic clk_i,
  input wire logic en_i,
  output logic pin_o
);
  initial pin_o = 1'b0;
  // each level stands until the next flip, well past two samplings
  always @(posedge clk_i) begin
    if (en_i) pin_o <= ~pin_o;
  end
endmodule : tmp_pulse_src

// ===== tb/tmp_timer_sva.sv
// checker bound to the timer block ports
// assumes classic wishbone masters on one clock
`timescale 1ns/100ps
module tmp_timer_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic watchdog_tick_o,
  input wire logic [7:0] timer_count_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic asg_q;
  wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire hit = wb_adr_i == 8'h04 || wb_adr_i == 8'h08 || wb_adr_i == 8'h0C;
  wire ld = tk && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h04;
  ////////////////////////////////////////
  // config is write-only, so shadow its assign bit here
  always_ff @(posedge clk_i) begin
    if (rst_i) asg_q <= 1'b1;
    else if (tk && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h08) asg_q <= wb_dat_i[3];
  end
  a_map_ack: assert property (tk && hit |=> wb_ack_o && !wb_err_o) else $error("ack");
  a_hole_err: assert property (tk && !hit |=> wb_err_o && !wb_ack_o) else $error("err");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_count_load:
    assert property (ld |=> timer_count_o == $past(wb_dat_i[7:0])) else $error("no load");
  a_read_count:
    assert property (tk && !wb_we_i && wb_adr_i == 8'h04 |=>
      wb_dat_o == {24'h0, $past(timer_count_o)}) else $error("bad read");
  a_load_hold:
    assert property (ld |=> ##1 $stable(timer_count_o)[*5]) else $error("no hold");
  a_step_one:
    assert property (!$stable(timer_count_o) && !$past(ld) |->
      timer_count_o == $past(timer_count_o) + 8'h01) else $error("bad step");
  a_tick_owner:
    assert property (!asg_q && !$past(asg_q) |-> !watchdog_tick_o) else $error("tick");
  c_wrap: cover property (timer_count_o == 8'h00 && $past(timer_count_o) == 8'hFF);
  c_hole: cover property (wb_err_o);
  c_tick: cover property (watchdog_tick_o);
endmodule : tmp_timer_chk
bind tmp_timer tmp_timer_chk chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .watchdog_tick_o, .timer_count_o);

// ===== tb/tmp_timer_test.sv
// bench for the timer block: register, timer, prescaler and pin tests
// assumes the checker binds itself and the pin source is compiled in
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %0t %0h %0h", $time, g, e); end end
module tmp_timer_test import tmp_pkg::*; ;
  logic clk, rst, req, we, wdc, en, ack, err, tick, pin, er;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, rd;
  tmp_byte_t cnt, v;
  int fail_count, num_checks, cyc_n;
  tmp_timer uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .external_count_input_i(pin), .watchdog_clear_instr_i(wdc),
    .watchdog_tick_o(tick), .timer_count_o(cnt));
  tmp_pulse_src src (.clk_i(clk), .en_i(en), .pin_o(pin));
  ////////////////////////////////////////
  // 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard, far above the ~8000 cycles the tests need
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // one classic cycle, held until ack or err is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input tmp_byte_t d);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    rd = rdat;
    er = err;
    req <= 1'b0;
    @(posedge clk);
  endtask : xfer
  // sync on a step, then expect two steps over two periods
  task automatic rate(input int per);
    v = cnt;
    for (int n = 0; n < 1200 && cnt === v; n++) @(posedge clk);
    v = cnt;
    repeat (2 * per) @(posedge clk);
    `CHK(cnt - v, 8'h02)
  endtask : rate
  // one pin level change, then time to sync and count
  task automatic flip();
    en <= 1'b1;
    @(posedge clk);
    en <= 1'b0;
    repeat (20) @(posedge clk);
  endtask : flip
  // main sequence
  initial begin
    {rst, req, we, wdc, en} = 5'h10;
    {adr, wdat} = '0;
    sel = 4'hF;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    `CHK(cnt, 8'h00)
    xfer(1'b0, 8'h08, 8'h00);
    `CHK(rd, 32'h0)
    xfer(1'b0, 8'h10, 8'h00);
    `CHK(er, 1'b1)
    xfer(1'b1, 8'h04, 8'hA5);
    sel <= 4'h0;
    xfer(1'b1, 8'h04, 8'h11);
    sel <= 4'hF;
    xfer(1'b0, 8'h04, 8'h00);
    `CHK(rd, 32'hA5)
    $display("test registers done");
    xfer(1'b1, 8'h08, 8'h08);
    xfer(1'b1, 8'h04, 8'hFE);
    rate(4);
    `CHK(cnt, 8'h01)
    xfer(1'b1, 8'h04, 8'h40);
    repeat (3) @(posedge clk);
    `CHK(cnt, 8'h40)
    $display("test timer done");
    xfer(1'b1, 8'h0C, 8'h01);
    wdc <= 1'b1;
    @(posedge clk);
    wdc <= 1'b0;
    for (int n = 0; n < 8; n++) begin
      xfer(1'b1, 8'h08, 8'(n));
      xfer(1'b1, 8'h04, 8'h00);
      rate(4 << (n + 1));
    end
    repeat (500) @(posedge clk);
    xfer(1'b1, 8'h04, 8'h00);
    repeat (1000) @(posedge clk);
    `CHK(cnt, 8'h00)
    $display("test prescaler done");
    xfer(1'b1, 8'h0C, 8'h01);
    xfer(1'b1, 8'h04, 8'h00);
    for (int e = 0; e < 2; e++) begin
      xfer(1'b1, 8'h08, 8'h28 | 8'(e << 4));
      xfer(1'b1, 8'h04, 8'h00);
      flip();
      `CHK(cnt, 8'(1 - e))
      flip();
      `CHK(cnt, 8'h01)
    end
    for (int n = 0; n < 16 && tick !== 1'b1; n++) @(posedge clk);
    `CHK(tick, 1'b1)
    $display("test counter done");
    report_and_stop();
  end
endmodule : tmp_timer_test
